// [scfg_regs.sv]
// configuration register bank behind the three-wire serial port
// assumes pins synchronous to clk; converter logic reads conv_active
`default_nettype none
module scfg_regs #(
   parameter logic [7:0] PART_ID = 8'hA5  // arbitrary value
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // serial pins
   input wire logic csb_n,
   input wire logic sclk,
   input wire logic sdio_i,
   output logic sdio_o,
   output logic sdio_oe,
   // live settings
   output logic lsb_first,
   output logic [7:0] port_setup,
   output logic [7:0] grade,
   output logic [7:0] index_2,
   output logic [7:0] index_1,
   output logic [scfg_pkg::CONV_N*8-1:0] conv_active,
   output logic dcs_enable,
   output logic commit_busy
);
   import scfg_pkg::*;
   scfg_access_if acc ();

   logic [7:0] port_r, grade_r, idx2_r, idx1_r;
   logic commit_r, soft_rst_r;
   logic [7:0] mst_r [CONV_N];
   logic [7:0] slv_r [CONV_N];

   scfg_serial_port u_port (
      .clk(clk),
      .rst(rst),
      .csb_n(csb_n),
      .sclk(sclk),
      .sdio_i(sdio_i),
      .sdio_o(sdio_o),
      .sdio_oe(sdio_oe),
      .acc(acc)
   );

   // decode
   wire in_conv = (acc.addr >= A_CONV_LO)
      && (acc.addr <= A_CONV_HI);
   wire [ADDR_W-1:0] conv_off = acc.addr - A_CONV_LO;
   wire [5:0] conv_idx = conv_off[5:0];
   wire wr_port = acc.wr && (acc.addr == A_PORT);
   wire wr_grade = acc.wr && (acc.addr == A_GRADE);
   wire wr_idx2 = acc.wr && (acc.addr == A_IDX2);
   wire wr_idx1 = acc.wr && (acc.addr == A_IDX1);
   wire wr_commit = acc.wr && (acc.addr == A_COMMIT)
      && acc.wdata[COMMIT_BIT];
   wire wr_conv = acc.wr && in_conv;
   // fixed bits of port setup are forced, not stored from the bus
   wire [7:0] port_wval = (acc.wdata & PORT_KEEP) | PORT_ONES;
   wire srst_req = wr_port
      && (acc.wdata[PORT_SRST_HI] || acc.wdata[PORT_SRST_LO]);
   // readback shows the pending master value of buffered registers
   wire [7:0] rd_conv = in_conv ? mst_r[conv_idx] : 8'h00;
   assign acc.rdata =
      (acc.addr == A_PORT) ? port_r :
      (acc.addr == A_PART) ? PART_ID :
      (acc.addr == A_GRADE) ? grade_r :
      (acc.addr == A_IDX2) ? idx2_r :
      (acc.addr == A_IDX1) ? idx1_r :
      (acc.addr == A_COMMIT) ? {7'h00, commit_r} : rd_conv;
   // either copy of the mirrored bit selects lsb-first order
   assign acc.lsb_first = port_r[PORT_LSB_HI] || port_r[PORT_LSB_LO];
   assign lsb_first = acc.lsb_first;
   assign port_setup = port_r;
   assign grade = grade_r;
   assign index_2 = idx2_r;
   assign index_1 = idx1_r;
   assign commit_busy = commit_r;
   assign dcs_enable = slv_r[CLOCK_IDX][0];

   genvar g;
   generate
      for (g = 0; g < CONV_N; g++) begin : g_out
         assign conv_active[g*8 +: 8] = slv_r[g];
      end
   endgenerate

   // direct registers act at once
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         port_r <= RST_PORT;
         grade_r <= RST_GRADE;
         idx2_r <= RST_IDX;
         idx1_r <= RST_IDX;
         soft_rst_r <= 1'b0;
      end else if (soft_rst_r) begin
         port_r <= RST_PORT;
         grade_r <= RST_GRADE;
         idx2_r <= RST_IDX;
         idx1_r <= RST_IDX;
         soft_rst_r <= 1'b0;
      end else begin
         soft_rst_r <= srst_req;
         if (wr_port) begin
            port_r <= port_wval;
         end
         if (wr_grade) begin
            grade_r <= acc.wdata & GRADE_KEEP;
         end
         if (wr_idx2) begin
            idx2_r <= acc.wdata & IDX2_KEEP;
         end
         if (wr_idx1) begin
            idx1_r <= acc.wdata & IDX1_KEEP;
         end
      end
   end

   // commit strobe: one cycle set, then cleared on the same edge as the copy
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         commit_r <= 1'b0;
      end else begin
         commit_r <= wr_commit && !soft_rst_r;
      end
   end

   // buffered converter registers, master and slave
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < CONV_N; i++) begin
            mst_r[i] <= conv_default(i);
            slv_r[i] <= conv_default(i);
         end
      end else if (soft_rst_r) begin
         for (int i = 0; i < CONV_N; i++) begin
            mst_r[i] <= conv_default(i);
            slv_r[i] <= conv_default(i);
         end
      end else begin
         if (wr_conv) begin
            mst_r[conv_idx] <= acc.wdata;
         end
         if (commit_r) begin
            for (int i = 0; i < CONV_N; i++) begin
               slv_r[i] <= mst_r[i];
            end
         end
      end
   end

   // checks
   property p_port_fixed;
      @(posedge clk) disable iff (rst)
      (port_r & ~PORT_KEEP) == PORT_ONES;
   endproperty
   a_port_fixed: assert property (p_port_fixed)
      else $error("port setup fixed bits wrong");

   property p_port_write;
      @(posedge clk) disable iff (rst)
      wr_port && !soft_rst_r |=> port_r == $past(port_wval);
   endproperty
   a_port_write: assert property (p_port_write)
      else $error("port setup write did not act at once");

   property p_part_id;
      @(posedge clk) disable iff (rst)
      acc.addr == A_PART |-> acc.rdata == PART_ID;
   endproperty
   a_part_id: assert property (p_part_id)
      else $error("part identifier readback wrong");

   property p_conv_held;
      @(posedge clk) disable iff (rst)
      !commit_r && !soft_rst_r |=> $stable(conv_active);
   endproperty
   a_conv_held: assert property (p_conv_held)
      else $error("active converter setting changed without commit");

   property p_commit_copy;
      @(posedge clk) disable iff (rst)
      commit_r && !soft_rst_r
         |=> slv_r[CLOCK_IDX] == $past(mst_r[CLOCK_IDX]);
   endproperty
   a_commit_copy: assert property (p_commit_copy)
      else $error("commit did not copy master value");

   property p_commit_clear;
      @(posedge clk) disable iff (rst)
      commit_r |=> !commit_r;
   endproperty
   a_commit_clear: assert property (p_commit_clear)
      else $error("commit strobe did not clear");

   property p_soft_reset;
      @(posedge clk) disable iff (rst)
      srst_req && !soft_rst_r |-> ##2 (port_r == RST_PORT
         && idx1_r == RST_IDX && slv_r[CLOCK_IDX] == RST_CLOCK);
   endproperty
   a_soft_reset: assert property (p_soft_reset)
      else $error("soft reset did not restore defaults");

   property p_index_mask;
      @(posedge clk) disable iff (rst)
      (idx2_r & ~IDX2_KEEP) == 8'h00 && (idx1_r & ~IDX1_KEEP) == 8'h00;
   endproperty
   a_index_mask: assert property (p_index_mask)
      else $error("index register holds undefined bits");

   property p_unmapped;
      @(posedge clk) disable iff (rst)
      acc.addr > A_CONV_HI && acc.addr != A_COMMIT |-> acc.rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped address did not read zero");
endmodule : scfg_regs
`default_nettype wire

// [scfg_pkg.sv]
// constants of the serial configuration register bank
// assumes one clock; the serial pins arrive synchronous to it
`default_nettype none
package scfg_pkg;
   localparam int ADDR_W = 13;
   localparam logic [ADDR_W-1:0] A_PORT = 13'h0000;
   localparam logic [ADDR_W-1:0] A_PART = 13'h0001;
   localparam logic [ADDR_W-1:0] A_GRADE = 13'h0002;
   localparam logic [ADDR_W-1:0] A_IDX2 = 13'h0004;
   localparam logic [ADDR_W-1:0] A_IDX1 = 13'h0005;
   localparam logic [ADDR_W-1:0] A_COMMIT = 13'h00FF;
   localparam logic [ADDR_W-1:0] A_CONV_LO = 13'h0008;
   localparam logic [ADDR_W-1:0] A_CONV_HI = 13'h002D;
   localparam int CONV_N = 38;
   localparam int CLOCK_IDX = 1;
   localparam logic [7:0] RST_PORT = 8'h18;
   localparam logic [7:0] PORT_ONES = 8'h18;
   localparam logic [7:0] PORT_KEEP = 8'h66;
   localparam int PORT_LSB_HI = 6;
   localparam int PORT_LSB_LO = 1;
   localparam int PORT_SRST_HI = 5;
   localparam int PORT_SRST_LO = 2;
   localparam logic [7:0] RST_GRADE = 8'h00;
   localparam logic [7:0] GRADE_KEEP = 8'h30;
   localparam logic [7:0] RST_IDX = 8'h0F;
   localparam logic [7:0] IDX2_KEEP = 8'h0F;
   localparam logic [7:0] IDX1_KEEP = 8'h3F;
   localparam logic [7:0] RST_CLOCK = 8'h01;
   localparam logic [7:0] RST_CONV = 8'h00;
   localparam int COMMIT_BIT = 0;
   // instruction word layout
   localparam int INS_RW = 15;
   localparam int INS_LEN_HI = 14;
   localparam int INS_LEN_LO = 13;
   localparam logic [1:0] LEN_STREAM = 2'h3;
   localparam logic [3:0] INS_LAST = 4'hF;
   localparam logic [3:0] BYTE_LAST = 4'h7;
   // default of each converter register, index 0 is address 0x08
   function automatic logic [7:0] conv_default(input int i);
      return (i == CLOCK_IDX) ? RST_CLOCK : RST_CONV;
   endfunction : conv_default
endpackage : scfg_pkg
`default_nettype wire

// [scfg_access_if.sv]
// byte access path from the serial port to the register bank
// assumes both ends share clk
`default_nettype none
interface scfg_access_if;
   import scfg_pkg::*;
   logic [ADDR_W-1:0] addr;
   logic wr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic lsb_first;
   modport port (output addr, output wr, output wdata,
                 input rdata, input lsb_first);
   modport bank (input addr, input wr, input wdata,
                 output rdata, output lsb_first);
endinterface : scfg_access_if
`default_nettype wire

// [scfg_serial_port.sv]
// serial frame decoder: 16-bit instruction, then 1-3 bytes or stream
// assumes pins synchronous to clk and sclk far slower than clk
`default_nettype none
module scfg_serial_port (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // serial pins
   input wire logic csb_n,
   input wire logic sclk,
   input wire logic sdio_i,
   output logic sdio_o,
   output logic sdio_oe,
   // register access
   scfg_access_if.port acc
);
   import scfg_pkg::*;
   typedef enum logic [1:0] {ST_INSTR, ST_DATA, ST_DONE} scfg_sp_state_t;
   scfg_sp_state_t state_r;
   logic sclk_q_r, rd_r, load_r, byte_end_r, oe_r;
   logic [3:0] cnt_r;
   logic [15:0] sh_r;
   logic [7:0] tx_r;
   logic [1:0] len_r, bytes_r;
   logic [ADDR_W-1:0] addr_r;

   function automatic logic [15:0] shift_in(input logic [15:0] v,
      input logic b, input logic lsb);
      return lsb ? {b, v[15:1]} : {v[14:0], b};
   endfunction : shift_in

   wire lsb = acc.lsb_first;
   wire rise = !csb_n && sclk && !sclk_q_r;
   wire [15:0] sh_nxt = shift_in(sh_r, sdio_i, lsb);
   wire [7:0] byte_nxt = lsb ? sh_nxt[15:8] : sh_nxt[7:0];
   wire last_byte = (len_r != LEN_STREAM) && (bytes_r == len_r);
   // streaming walks down in msb-first mode and up in lsb-first mode
   wire [ADDR_W-1:0] addr_step = lsb ? addr_r + 1'b1 : addr_r - 1'b1;

   assign acc.addr = addr_r;
   assign acc.wr = byte_end_r && !rd_r;
   assign sdio_o = lsb ? tx_r[0] : tx_r[7];
   assign sdio_oe = oe_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= ST_INSTR;
         sclk_q_r <= 1'b0;
         rd_r <= 1'b0;
         load_r <= 1'b0;
         byte_end_r <= 1'b0;
         oe_r <= 1'b0;
         cnt_r <= '0;
         sh_r <= '0;
         tx_r <= '0;
         len_r <= '0;
         bytes_r <= '0;
         addr_r <= '0;
         acc.wdata <= '0;
      end else begin
         sclk_q_r <= sclk;
         load_r <= 1'b0;
         byte_end_r <= 1'b0;
         if (load_r) begin
            tx_r <= acc.rdata;
         end
         if (byte_end_r) begin
            addr_r <= addr_step;
            load_r <= rd_r && (state_r == ST_DATA);
         end
         if (csb_n) begin
            // a frame cut short resets the decoder
            state_r <= ST_INSTR;
            cnt_r <= '0;
            oe_r <= 1'b0;
         end else if (rise) begin
            sh_r <= sh_nxt;
            cnt_r <= cnt_r + 1'b1;
            case (state_r)
               ST_INSTR: begin
                  if (cnt_r == INS_LAST) begin
                     rd_r <= sh_nxt[INS_RW];
                     len_r <= sh_nxt[INS_LEN_HI:INS_LEN_LO];
                     addr_r <= sh_nxt[ADDR_W-1:0];
                     bytes_r <= '0;
                     load_r <= sh_nxt[INS_RW];
                     oe_r <= sh_nxt[INS_RW];
                     cnt_r <= '0;
                     state_r <= ST_DATA;
                  end
               end
               ST_DATA: begin
                  tx_r <= lsb ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
                  if (cnt_r == BYTE_LAST) begin
                     acc.wdata <= byte_nxt;
                     byte_end_r <= 1'b1;
                     bytes_r <= bytes_r + 1'b1;
                     cnt_r <= '0;
                     if (last_byte) begin
                        state_r <= ST_DONE;
                        oe_r <= 1'b0;
                     end
                  end
               end
               ST_DONE: begin
                  cnt_r <= '0;
               end
               default: begin
                  state_r <= ST_INSTR;
               end
            endcase
         end
      end
   end
endmodule : scfg_serial_port
`default_nettype wire

// [scfg_host_model.sv]
// host side of the three-wire serial control port, one- and two-byte frames
// assumes the device samples its pins on rising clk
`default_nettype none
module scfg_host_model (
   // clock
   input wire logic clk,
   // serial pins
   output logic csb_n,
   output logic sclk,
   output logic sdio_d,
   output logic sdio_en,
   input wire logic sdio_line
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      csb_n = 1'b1;
      sclk = 1'b0;
      sdio_d = 1'b0;
      sdio_en = 1'b0;
   end

   // four clk per half period keeps the device's edge detector happy
   task automatic bit_cyc(input logic b, input logic drv, output logic s);
      sdio_en = drv;
      sdio_d = b;
      repeat (4) @(negedge clk);
      s = sdio_line;
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      sclk = 1'b0;
   endtask : bit_cyc

   // callers write defined places and also unmapped 0x002E, fixed bits as published, mirrored
   // nibbles alike, and commit only after the 0x0009 write and the 0x0008/0x002D/0x002E writes, not after each sequence
   // short nbits aborts mid-byte
   task automatic xfer(input logic rd, input logic [12:0] a,
         input logic [7:0] wd, input logic lsb, input int nbits,
         output logic [7:0] rdat);
      logic [15:0] ins;
      logic s;
      ins = {rd, 2'b00, a};
      rdat = 8'h00;
      @(negedge clk);
      csb_n = 1'b0;
      for (int i = 0; i < 16; i++) begin
         bit_cyc(lsb ? ins[i] : ins[15-i], 1'b1, s);
      end
      for (int i = 0; i < nbits; i++) begin
         bit_cyc(lsb ? wd[i] : wd[7-i], ~rd, s);
         if (lsb) begin
            rdat[i] = s;
         end else begin
            rdat[7-i] = s;
         end
      end
      sdio_en = 1'b0;
      csb_n = 1'b1;
      repeat (8) @(negedge clk);
   endtask : xfer

   // two-byte write frame; the second byte goes one address down in msb-first order, up in lsb-first
   task automatic wr_pair(input logic [12:0] a, input logic [7:0] b0,
         input logic [7:0] b1, input logic lsb);
      logic [15:0] ins;
      logic [7:0] d;
      logic s;
      ins = {1'b0, 2'b01, a};
      @(negedge clk);
      csb_n = 1'b0;
      for (int i = 0; i < 16; i++) begin
         bit_cyc(lsb ? ins[i] : ins[15-i], 1'b1, s);
      end
      for (int j = 0; j < 2; j++) begin
         d = (j == 0) ? b0 : b1;
         for (int i = 0; i < 8; i++) begin
            bit_cyc(lsb ? d[i] : d[7-i], 1'b1, s);
         end
      end
      sdio_en = 1'b0;
      csb_n = 1'b1;
      repeat (8) @(negedge clk);
   endtask : wr_pair
endmodule : scfg_host_model
`default_nettype wire

// [tb.sv]
// self-checking bench of the serial configuration register bank
// assumes the host model above; sclk stands low between frames
`default_nettype none
module tb;
   import scfg_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] PID = 8'hA5;  // arbitrary value
   logic clk, rst, csb_n, sclk, sdio_d, sdio_en, sdio_line;
   logic sdio_o, sdio_oe, lsb_first, dcs_enable, commit_busy, lsb_mode;
   logic [7:0] port_setup, grade, index_2, index_1, junk;
   logic [CONV_N*8-1:0] conv_active;
   int err_total = 0;
   int cmp_count = 0;
   int commit_seen = 0;

   // device wins; an undriven line shows the inverse of the last bit
   assign sdio_line = sdio_oe ? sdio_o : (sdio_en ? sdio_d : ~sdio_d);

   scfg_regs #(.PART_ID(PID)) scfg_regs_i (
      .clk(clk), .rst(rst), .csb_n(csb_n), .sclk(sclk),
      .sdio_i(sdio_line), .sdio_o(sdio_o), .sdio_oe(sdio_oe),
      .lsb_first(lsb_first), .port_setup(port_setup), .grade(grade),
      .index_2(index_2), .index_1(index_1), .conv_active(conv_active),
      .dcs_enable(dcs_enable), .commit_busy(commit_busy));

   scfg_host_model scfg_host_model_i (
      .clk(clk), .csb_n(csb_n), .sclk(sclk), .sdio_d(sdio_d),
      .sdio_en(sdio_en), .sdio_line(sdio_line));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk) begin
      if (commit_busy === 1'b1) begin
         commit_seen++;
      end
   end

   task automatic close_out;
      $display("compares=%0d mismatches=%0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      logic [7:0] x;
      scfg_host_model_i.xfer(1'b0, a, d, lsb_mode, 8, x);
   endtask : wr

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
      logic [7:0] x;
      scfg_host_model_i.xfer(1'b1, a, 8'h00, lsb_mode, 8, x);
      chk(x, e);
   endtask : rd_chk

   task automatic chk_dflt;
      chk(port_setup, 8'h18);
      chk(index_1, 8'h0F);
      chk(index_2, 8'h0F);
      chk(grade, 8'h00);
      chk(conv_active[15:8], 8'h01);
      chk({7'h00, dcs_enable}, 8'h01);
      chk({7'h00, lsb_first}, 8'h00);
      chk({7'h00, sdio_oe}, 8'h00);
   endtask : chk_dflt

   initial begin
      rst = 1'b1;
      lsb_mode = 1'b0;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      chk_dflt();
      rd_chk(A_PORT, 8'h18);
      rd_chk(A_PART, PID);
      rd_chk(13'h0009, 8'h01);
      wr(A_PART, 8'h5A);
      rd_chk(A_PART, PID);
      // stabilizer off stays pending until the commit
      wr(13'h0009, 8'h00);
      chk({7'h00, dcs_enable}, 8'h01);
      rd_chk(13'h0009, 8'h00);
      wr(A_COMMIT, 8'h01);
      chk(8'(commit_seen), 8'h01);
      chk({7'h00, dcs_enable}, 8'h00);
      rd_chk(A_COMMIT, 8'h00);
      // unbuffered registers act at once
      wr(A_IDX1, 8'h3C);
      chk(index_1, 8'h3C);
      wr(A_IDX2, 8'h0A);
      chk(index_2, 8'h0A);
      wr(A_GRADE, 8'h10);
      chk(grade, 8'h10);
      // both ends of the converter block share one commit
      wr(A_CONV_LO, 8'h07);
      wr(A_CONV_HI, 8'hA5);
      wr(13'h002E, 8'h33);
      chk(conv_active[7:0], 8'h00);
      wr(A_COMMIT, 8'h01);
      chk(conv_active[7:0], 8'h07);
      chk(conv_active[303:296], 8'hA5);
      chk(8'(commit_seen), 8'h02);
      rd_chk(13'h002E, 8'h00);
      // half a byte then chip select high: nothing written
      scfg_host_model_i.xfer(1'b0, 13'h000A, 8'hFF, lsb_mode, 4,
         junk);
      rd_chk(13'h000A, 8'h00);
      // two-byte frame walks the address down in msb-first order
      scfg_host_model_i.wr_pair(13'h000B, 8'h11, 8'h22, lsb_mode);
      rd_chk(13'h000B, 8'h11);
      rd_chk(13'h000A, 8'h22);
      // both mirrored copies of the bit order select
      wr(A_PORT, 8'h5A);
      lsb_mode = 1'b1;
      chk(port_setup, 8'h5A);
      chk({7'h00, lsb_first}, 8'h01);
      rd_chk(A_PART, PID);
      rd_chk(A_PORT, 8'h5A);
      // lsb-first frames walk the address up
      scfg_host_model_i.wr_pair(13'h000C, 8'h44, 8'h55, lsb_mode);
      rd_chk(13'h000C, 8'h44);
      rd_chk(13'h000D, 8'h55);
      // soft reset on both copies brings back msb-first and defaults
      wr(A_PORT, 8'h3C);
      lsb_mode = 1'b0;
      chk_dflt();
      wr(A_IDX1, 8'h21);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      chk_dflt();
      close_out();
   end

   // about 30 frames of some 200 clk each
   initial begin
      repeat (30000) @(posedge clk);
      err_total++;
      close_out();
   end
endmodule : tb
`default_nettype wire
